// [dv/csm_host_model.sv]
// host side model driving the register and special function ports
`timescale 1ns/100ps
module csm_host_model #(
	parameter int STEP_CYC = 20 // cycles per step
) (
	input  wire logic           ref_clk,     // clock
	output csm_pkg::csm_regbus_s reg_bus,    // register port
	output csm_pkg::csm_sfcmd_s  sf_cmd,     // special function
	input  wire logic [7:0]     reg_rd_data  // read data
);
	import csm_pkg::*;
	// idle port at time zero
	initial begin
		reg_bus = '0;
		sf_cmd = '0;
	end
	// one write; reserved enable bits go out as zero
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_bus.addr = a;
		reg_bus.wdata = (a == ADDR_FUNC_ENABLE) ? (d & FUNC_ENABLE_MASK) : d;
		reg_bus.wr = 1'b1;
		@(negedge ref_clk);
		reg_bus.wr = 1'b0;
		reg_bus.wdata = ~reg_bus.wdata; // released data is not kept
	endtask
	// one read, data taken the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_bus.addr = a;
		reg_bus.rd = 1'b1;
		@(negedge ref_clk);
		reg_bus.rd = 1'b0;
		d = reg_rd_data;
	endtask
	// interrupt clear command, self releasing
	task automatic irq_clear();
		@(negedge ref_clk);
		sf_cmd.code = SF_IRQ_CLEAR;
		sf_cmd.valid = 1'b1;
		@(negedge ref_clk);
		sf_cmd.valid = 1'b0;
		sf_cmd.code = ~sf_cmd.code;
	endtask
	// power on, one step settle, then the requested functions
	task automatic power_up(input logic [7:0] en);
		wr(ADDR_FUNC_ENABLE, 8'h01);
		repeat (STEP_CYC + 2) @(negedge ref_clk);
		wr(ADDR_FUNC_ENABLE, en);
	endtask
endmodule

// [dv/csm_measure_ctrl_asserts.sv]
// port checker of the colour sensor measurement control
`timescale 1ns/100ps
module csm_measure_ctrl_chk #(
	parameter int STEP_CYC = 20 // cycles per step
) (
	input wire logic                 ref_clk,      // clock
	input wire logic                 rst,          // reset
	input wire csm_pkg::csm_regbus_s reg_bus,      // register port
	input wire csm_pkg::csm_sfcmd_s  sf_cmd,       // special function
	input wire logic [7:0]           reg_rd_data,  // read data
	input wire logic [15:0]          clear_result, // converter count
	input wire logic                 osc_on,       // oscillator
	input wire logic                 integrating,  // integrating
	input wire logic                 integ_done,   // end pulse
	input wire logic                 result_ready, // status bit zero
	input wire logic                 irq_n         // interrupt pin
);
	import csm_pkg::*;
	logic [16:0] run_ff; // consecutive integrating cycles
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// run length of the current integration
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_ff <= '0;
		end else begin
			run_ff <= integrating ? run_ff + 17'h1 : '0;
		end
	end
	osc_gate_a: assert property (!osc_on |-> !integrating)
		else $error("integrating with oscillator off");
	warm_up_a: assert property ($rose(osc_on) |-> !integrating [*8])
		else $error("integration without warm-up");
	integ_len_a: assert property (integ_done |-> run_ff >= STEP_CYC - 1)
		else $error("integration shorter than one step");
	done_pulse_a: assert property (integ_done |=> !integ_done)
		else $error("done pulse too long");
	done_ready_a: assert property (integ_done |-> result_ready)
		else $error("result not flagged at done");
	stat_read_a: assert property (reg_bus.rd && reg_bus.addr == ADDR_STATUS
		|=> reg_rd_data[BIT_RESULT_READY] == $past(result_ready))
		else $error("status bit zero wrong");
	gate_off_a: assert property (reg_bus.wr && reg_bus.addr == ADDR_FUNC_ENABLE
		&& !reg_bus.wdata[BIT_MEAS_IRQ_GATE] |=> irq_n)
		else $error("interrupt with gate off");
	irq_clr_a: assert property (sf_cmd.valid && sf_cmd.code == SF_IRQ_CLEAR
		&& !integrating |=> irq_n)
		else $error("interrupt not cleared");
	irq_hold_a: assert property (!irq_n && !sf_cmd.valid && !reg_bus.wr |=> !irq_n)
		else $error("interrupt dropped on its own");
	cover property (integ_done);
	cover property ($fell(irq_n));
	cover property ($rose(irq_n) && osc_on);
endmodule
bind csm_measure_ctrl csm_measure_ctrl_chk #(.STEP_CYC(STEP_CYC)) chk_u (
	.ref_clk      (ref_clk),
	.rst          (rst),
	.reg_bus      (reg_bus),
	.sf_cmd       (sf_cmd),
	.reg_rd_data  (reg_rd_data),
	.clear_result (clear_result),
	.osc_on       (osc_on),
	.integrating  (integrating),
	.integ_done   (integ_done),
	.result_ready (result_ready),
	.irq_n        (irq_n)
);

// [dv/tb_top.sv]
// self-checking bench of the colour sensor measurement control
`timescale 1ns/100ps
module tb_top;
	import csm_pkg::*;
	localparam int SC = 20;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] clear_result = '0;
	csm_regbus_s reg_bus;
	csm_sfcmd_s  sf_cmd;
	logic [7:0]  rdat;
	logic [7:0]  rdat_q;
	logic        osc_on, integrating, integ_done, result_ready, irq_n;
	int          num_errors = 0;
	int          n_compared = 0;
	csm_measure_ctrl #(.STEP_CYC(SC)) dut_u (.ref_clk(ref_clk), .rst(rst), .reg_bus(reg_bus),
		.sf_cmd(sf_cmd), .reg_rd_data(rdat), .clear_result(clear_result), .osc_on(osc_on),
		.integrating(integrating), .integ_done(integ_done), .result_ready(result_ready),
		.irq_n(irq_n));
	csm_host_model #(.STEP_CYC(SC)) host_u (.ref_clk(ref_clk), .reg_bus(reg_bus),
		.sf_cmd(sf_cmd), .reg_rd_data(rdat));
	// clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// cycles until the next end-of-integration pulse, bounded
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (integ_done !== 1'b1 && n < 8000);
		if (n >= 8000) check("done pulse", 16'h0, 16'h1);
	endtask
	task automatic rd16(input logic [4:0] a, output logic [15:0] v);
		logic [7:0] lo, hi;
		host_u.rd(a, lo);
		host_u.rd(a + 5'h1, hi);
		v = {hi, lo};
	endtask
	// reset values, byte pairs, read-only status and one unmapped place
	task automatic t_regs();
		logic [4:0] ra [11] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c,
			5'h0d, 5'h13, 5'h02};
		logic [7:0] rv [11] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00};
		logic [15:0] v;
		foreach (ra[i]) begin
			host_u.rd(ra[i], rdat_q);
			check("reset value", {8'h0, rdat_q}, {8'h0, rv[i]});
		end
		host_u.wr(ADDR_STATUS, 8'h11);
		host_u.rd(ADDR_STATUS, rdat_q);
		check("status read-only", {8'h0, rdat_q}, 16'h0);
		host_u.wr(ADDR_LOW_THR_LO, 8'h00);
		host_u.wr(ADDR_LOW_THR_HI, 8'h01);
		host_u.wr(ADDR_HIGH_THR_LO, 8'h00);
		host_u.wr(ADDR_HIGH_THR_HI, 8'h02);
		rd16(ADDR_LOW_THR_LO, v);
		check("low threshold", v, 16'h0100);
		rd16(ADDR_HIGH_THR_LO, v);
		check("high threshold", v, 16'h0200);
	endtask
	// integration length and result ceiling
	task automatic t_integ();
		logic [7:0] ip [3] = '{8'hfe, 8'hc1, 8'hc0};
		logic [15:0] cap [3] = '{16'h0800, 16'hfc00, 16'hffff};
		logic [15:0] v;
		int n;
		clear_result = 16'hffff;
		host_u.wr(ADDR_FUNC_ENABLE, 8'h01);
		@(negedge ref_clk);
		check("oscillator on", osc_on, 1'b1);
		repeat (SC / 2) @(negedge ref_clk);
		check("warm-up idle", integrating, 1'b0);
		repeat (SC) @(negedge ref_clk);
		host_u.wr(ADDR_FUNC_ENABLE, 8'h03);
		foreach (ip[i]) begin
			host_u.wr(ADDR_INTEG_PERIOD, ip[i]);
			wait_done(n);
			wait_done(n);
			check("integ length", n >= (256 - ip[i]) * SC && n <= (256 - ip[i]) * SC + 2, 1);
			rd16(ADDR_CLEAR_LO, v);
			check("clear ceiling", v, cap[i]);
			host_u.rd(ADDR_STATUS, rdat_q);
			check("result ready", rdat_q[BIT_RESULT_READY], 1'b1);
		end
	endtask
	// wait period with and without stretch
	task automatic t_wait();
		int n;
		host_u.wr(ADDR_INTEG_PERIOD, 8'hff);
		host_u.wr(ADDR_WAIT_PERIOD, 8'hfe);
		host_u.wr(ADDR_CONFIG, 8'h02);
		host_u.wr(ADDR_FUNC_ENABLE, 8'h0b);
		wait_done(n);
		wait_done(n);
		check("stretched wait", n >= 25 * SC && n <= 25 * SC + 4, 1);
		host_u.wr(ADDR_CONFIG, 8'h00);
		wait_done(n);
		wait_done(n);
		check("plain wait", n >= 3 * SC && n <= 3 * SC + 4, 1);
	endtask
	// two integrations with a given result, then the pin
	task automatic irq_step(input logic [15:0] res, input logic exp_n, input string what);
		int n;
		clear_result = res;
		wait_done(n);
		wait_done(n);
		check(what, irq_n, exp_n);
	endtask
	task automatic t_irq();
		int n;
		host_u.wr(ADDR_FUNC_ENABLE, 8'h13);
		irq_step(16'h0150, 1'b0, "every cycle irq");
		repeat (4) @(negedge ref_clk);
		check("irq held", irq_n, 1'b0);
		host_u.irq_clear();
		check("irq cleared", irq_n, 1'b1);
		host_u.wr(ADDR_FUNC_ENABLE, 8'h03);
		irq_step(16'h0150, 1'b1, "gate off");
		host_u.wr(ADDR_INT_FILTER, 8'h01);
		host_u.wr(ADDR_FUNC_ENABLE, 8'h13);
		irq_step(16'h0150, 1'b1, "in range");
		irq_step(16'h0300, 1'b0, "above high");
		host_u.irq_clear();
		irq_step(16'h0150, 1'b1, "count reset");
		host_u.wr(ADDR_INT_FILTER, 8'h02);
		clear_result = 16'h0050;
		wait_done(n);
		check("first outlier", irq_n, 1'b1);
		wait_done(n);
		check("second outlier", irq_n, 1'b0);
		host_u.irq_clear();
		host_u.wr(ADDR_INT_FILTER, 8'h07);
		irq_step(16'h0150, 1'b1, "in range again");
		clear_result = 16'h0050;
		repeat (19) wait_done(n);
		check("nineteen outliers", irq_n, 1'b1);
		wait_done(n);
		check("twentieth outlier", irq_n, 1'b0);
		host_u.irq_clear();
		host_u.wr(ADDR_FUNC_ENABLE, 8'h00);
		repeat (2) @(negedge ref_clk);
		check("oscillator off", osc_on, 1'b0);
	endtask
	// watchdog
	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		t_regs();
		t_integ();
		t_wait();
		t_irq();
		print_verdict();
	end
endmodule

// [logic/csm_measure_ctrl.sv]
// measurement sequencer, threshold compare and interrupt of the colour sensor
`timescale 1ns/100ps

module csm_measure_ctrl #(
	parameter int STEP_CYC = csm_pkg::STEP_CYCLES // cycles per 2.4 ms step
) (
	input  wire logic               ref_clk,      // 40 MHz clock
	input  wire logic               rst,          // async reset, active high
	input  wire csm_pkg::csm_regbus_s reg_bus,    // register port from command decoder
	input  wire csm_pkg::csm_sfcmd_s  sf_cmd,     // special function strobe
	output logic [7:0]              reg_rd_data,  // read data, one cycle after rd
	input  wire logic [15:0]        clear_result, // clear channel count from converter
	output logic                    osc_on,       // oscillator running
	output logic                    integrating,  // converters integrating
	output logic                    integ_done,   // pulse: integration finished
	output logic                    result_ready, // status bit zero
	output logic                    irq_n         // interrupt pin, active low
);
	import csm_pkg::*;

	// sequencer states:
	//   off   - oscillator stopped, every timer held at zero
	//   warm  - one step of settling after power-on
	//   ready - oscillator running, conversions not enabled
	//   integ - colour channels integrating, one step per tick
	//   wait  - optional pause between integrations
	// one step is STEP_CYC clocks; with stretch on, twelve ticks make a wait step
	//
	// hazards:
	//   periods may be rewritten mid-run; the phase ends at the next tick once
	//   the step count has reached the new length, so nothing wraps around
	//   the persistence count survives an interrupt clear; only an in-range
	//   result, stopping conversions or dropping the oscillator brings it back to zero
	//   the interrupt flag is kept while powered down, only the clear drops it

	csm_core_s cur_ff;
	csm_core_s nxt_cur;

	// register write decode, used for every writable register
	function automatic logic wr_hit(input csm_regbus_s b, input logic [4:0] a);
		wr_hit = b.wr && (b.addr == a);
	endfunction

	// consecutive out-of-range results needed for a filter code
	function automatic logic [5:0] filter_need(input logic [3:0] code);
		logic [5:0] c6;
		c6 = {2'h0, code};
		filter_need = c6;
		if (code <= FILTER_LINEAR) begin
			filter_need = c6;
		end else if (code >= FILTER_STEP5) begin
			filter_need = 6'((c6 - {2'h0, FILTER_LINEAR}) * FILTER_FIVE);
		end else begin
			case (code)
				4'h4:    filter_need = FILTER_FIVE;
				4'h5:    filter_need = FILTER_TEN;
				default: filter_need = FILTER_FIFTEEN;
			endcase
		end
	endfunction

	// register read mux
	function automatic logic [7:0] rd_mux(input csm_core_s s, input logic [4:0] a);
		case (a)
			ADDR_FUNC_ENABLE:  rd_mux = s.func_enable;
			ADDR_INTEG_PERIOD: rd_mux = s.integration_period;
			ADDR_WAIT_PERIOD:  rd_mux = s.wait_period;
			ADDR_LOW_THR_LO:   rd_mux = s.low_threshold[7:0];
			ADDR_LOW_THR_HI:   rd_mux = s.low_threshold[15:8];
			ADDR_HIGH_THR_LO:  rd_mux = s.high_threshold[7:0];
			ADDR_HIGH_THR_HI:  rd_mux = s.high_threshold[15:8];
			ADDR_INT_FILTER:   rd_mux = s.interrupt_filter;
			ADDR_CONFIG:       rd_mux = s.config_reg;
			ADDR_STATUS: begin
				rd_mux = 8'h00;
				rd_mux[BIT_RESULT_READY]   = s.result_ready;
				rd_mux[BIT_CLEAR_IRQ_FLAG] = s.clear_chan_irq_flag;
			end
			ADDR_CLEAR_LO:     rd_mux = s.clear_data[7:0];
			ADDR_CLEAR_HI:     rd_mux = s.clear_data[15:8];
			default:           rd_mux = 8'h00;
		endcase
	endfunction

	// control bits and derived values
	logic        oscillator_power_on;
	logic        conversion_enable;
	logic        wait_enable;
	logic        measure_irq_gate;
	logic        wait_stretch_x12;
	logic [3:0]  filter_count_select;
	logic [8:0]  integ_steps;
	logic [8:0]  wait_steps;
	logic        step_tick;
	logic [18:0] max_count;
	logic [15:0] clamped;
	logic        below_low;
	logic        above_high;
	logic        out_of_range;
	logic [5:0]  persist_next;
	logic [8:0]  step_next;
	logic        integ_last;
	logic        wait_last;
	logic        irq_clear_req;

	// field extraction and arithmetic on the current state
	always_comb begin
		oscillator_power_on = cur_ff.func_enable[BIT_OSC_POWER_ON];
		conversion_enable   = cur_ff.func_enable[BIT_CONV_ENABLE];
		wait_enable         = cur_ff.func_enable[BIT_WAIT_ENABLE];
		measure_irq_gate    = cur_ff.func_enable[BIT_MEAS_IRQ_GATE];
		wait_stretch_x12    = cur_ff.config_reg[BIT_WAIT_STRETCH];
		filter_count_select = cur_ff.interrupt_filter[3:0];
		integ_steps = FULL_PERIOD - {1'b0, cur_ff.integration_period};
		wait_steps  = FULL_PERIOD - {1'b0, cur_ff.wait_period};
		step_tick   = (cur_ff.cycle_cnt == 17'(STEP_CYC - 1));
		// end of phase; >= lets a period shortened mid-run end at the next tick
		step_next   = cur_ff.step_cnt + 9'h001;
		integ_last  = (step_next >= integ_steps);
		wait_last   = (step_next >= wait_steps);
		// result ceiling: steps times 1024, held to the 16-bit range
		max_count   = {integ_steps, 10'h000};
		if (max_count > MAX_COUNT_SAT) begin
			max_count = MAX_COUNT_SAT;
		end
		// a count above the ceiling is cut to the ceiling before the compare
		if ({3'h0, clear_result} > max_count) begin
			clamped = max_count[15:0];
		end else begin
			clamped = clear_result;
		end
		// below the low or above the high threshold is out of range
		below_low    = (clamped < cur_ff.low_threshold);
		above_high   = (clamped > cur_ff.high_threshold);
		out_of_range = below_low || above_high;
		// persistence count stops at its top instead of wrapping to zero
		persist_next = cur_ff.persist_cnt;
		if (persist_next != 6'h3f) begin
			persist_next = persist_next + 6'h01;
		end
		// interrupt clear request from the special function port
		irq_clear_req = sf_cmd.valid && (sf_cmd.code == SF_IRQ_CLEAR);
	end

	// next state of the whole block
	always_comb begin
		nxt_cur            = cur_ff;
		nxt_cur.integ_done = 1'b0;

		// register writes
		// reserved bits are dropped here, so they always read back as zero
		if (wr_hit(reg_bus, ADDR_FUNC_ENABLE)) begin
			nxt_cur.func_enable = reg_bus.wdata & FUNC_ENABLE_MASK;
		end
		if (wr_hit(reg_bus, ADDR_INTEG_PERIOD)) begin
			nxt_cur.integration_period = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_WAIT_PERIOD)) begin
			nxt_cur.wait_period = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_LOW_THR_LO)) begin
			nxt_cur.low_threshold[7:0] = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_LOW_THR_HI)) begin
			nxt_cur.low_threshold[15:8] = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_HIGH_THR_LO)) begin
			nxt_cur.high_threshold[7:0] = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_HIGH_THR_HI)) begin
			nxt_cur.high_threshold[15:8] = reg_bus.wdata;
		end
		if (wr_hit(reg_bus, ADDR_INT_FILTER)) begin
			nxt_cur.interrupt_filter = reg_bus.wdata & FILTER_MASK;
		end
		if (wr_hit(reg_bus, ADDR_CONFIG)) begin
			nxt_cur.config_reg = reg_bus.wdata & CONFIG_MASK;
		end

		// register reads, answered one cycle later
		// the answer is held until the next read strobe
		if (reg_bus.rd) begin
			nxt_cur.rd_data = rd_mux(cur_ff, reg_bus.addr);
		end

		// interrupt clear command; a set below in the same cycle wins
		if (irq_clear_req) begin
			nxt_cur.clear_chan_irq_flag = 1'b0;
		end

		// step timer runs only with the oscillator on
		if (cur_ff.state == ST_OFF || cur_ff.state == ST_READY || step_tick) begin
			nxt_cur.cycle_cnt = 17'h00000;
		end else begin
			nxt_cur.cycle_cnt = cur_ff.cycle_cnt + 17'h00001;
		end

		// sequencer
		case (cur_ff.state)
			ST_OFF: begin
				// setting the power bit starts the warm-up step
				if (oscillator_power_on) begin
					nxt_cur.state = ST_WARM;
				end
			end
			ST_WARM: begin
				// one step of oscillator settling before the first integration
				if (step_tick) begin
					nxt_cur.state = ST_READY;
				end
			end
			ST_READY: begin
				// counters start from zero for a fresh integration
				if (conversion_enable) begin
					nxt_cur.state       = ST_INTEG;
					nxt_cur.step_cnt    = 9'h000;
					nxt_cur.stretch_cnt = 4'h0;
				end
			end
			ST_INTEG: begin
				if (step_tick) begin
					nxt_cur.step_cnt = step_next;
					if (integ_last) begin
						nxt_cur.integ_done   = 1'b1;
						nxt_cur.clear_data   = clamped;
						nxt_cur.result_ready = 1'b1;
						nxt_cur.step_cnt     = 9'h000;
						nxt_cur.stretch_cnt  = 4'h0;
						// threshold filter; set wins over a clear in this cycle
						if (measure_irq_gate) begin
							if (filter_count_select == FILTER_EVERY) begin
								nxt_cur.clear_chan_irq_flag = 1'b1;
							end else if (out_of_range) begin
								nxt_cur.persist_cnt = persist_next;
								if (persist_next >= filter_need(filter_count_select)) begin
									nxt_cur.clear_chan_irq_flag = 1'b1;
								end
							end else begin
								nxt_cur.persist_cnt = 6'h00;
							end
						end
						// with the wait timer off the next integration follows at once
						if (wait_enable) begin
							nxt_cur.state = ST_WAIT;
						end
					end
				end
			end
			ST_WAIT: begin
				if (step_tick) begin
					// with stretch on, twelve ticks make one wait step
					if (wait_stretch_x12 && cur_ff.stretch_cnt != STRETCH_LAST) begin
						nxt_cur.stretch_cnt = cur_ff.stretch_cnt + 4'h1;
					end else begin
						nxt_cur.stretch_cnt = 4'h0;
						nxt_cur.step_cnt    = step_next;
						if (wait_last) begin
							nxt_cur.step_cnt = 9'h000;
							nxt_cur.state    = ST_INTEG;
						end
					end
				end
				// switching the wait timer off restarts the step timer, so the
				// integration that follows still gets whole steps
				if (!wait_enable) begin
					nxt_cur.state       = ST_INTEG;
					nxt_cur.cycle_cnt   = 17'h00000;
					nxt_cur.step_cnt    = 9'h000;
					nxt_cur.stretch_cnt = 4'h0;
				end
			end
			default: begin
				nxt_cur.state = ST_OFF;
			end
		endcase

		// disabling conversions parks the sequencer, dropping the oscillator stops all
		if (!conversion_enable &&
			(cur_ff.state == ST_INTEG || cur_ff.state == ST_WAIT)) begin
			nxt_cur.state        = ST_READY;
			nxt_cur.integ_done   = 1'b0;
			nxt_cur.result_ready = 1'b0;
			nxt_cur.persist_cnt  = 6'h00;
		end
		// a done pulse landing on the same edge is dropped with the run
		if (!oscillator_power_on) begin
			nxt_cur.state        = ST_OFF;
			nxt_cur.integ_done   = 1'b0;
			nxt_cur.result_ready = 1'b0;
			nxt_cur.persist_cnt  = 6'h00;
			nxt_cur.step_cnt     = 9'h000;
			nxt_cur.stretch_cnt  = 4'h0;
		end
	end

	// state register
	// reset puts every register at its reset value and the sequencer off
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_ff                     <= '0;
			cur_ff.func_enable         <= RST_FUNC_ENABLE;
			cur_ff.integration_period  <= RST_PERIOD;
			cur_ff.wait_period         <= RST_PERIOD;
			cur_ff.interrupt_filter    <= RST_ZERO;
			cur_ff.config_reg          <= RST_ZERO;
			cur_ff.state               <= ST_OFF;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// outputs straight from the state register
	// the pin is gated by enable bit four too, so clearing it drops the pin at once
	assign reg_rd_data  = cur_ff.rd_data;
	assign osc_on       = (cur_ff.state != ST_OFF);
	assign integrating  = (cur_ff.state == ST_INTEG);
	assign integ_done   = cur_ff.integ_done;
	assign result_ready = cur_ff.result_ready;
	assign irq_n        = ~(cur_ff.clear_chan_irq_flag & measure_irq_gate);

endmodule

// [logic/csm_pkg.sv]
// constants, types and register map of the colour sensor measurement control
package csm_pkg;

	// register indices on the internal register port
	localparam logic [4:0] ADDR_FUNC_ENABLE   = 5'h00;
	localparam logic [4:0] ADDR_INTEG_PERIOD  = 5'h01;
	localparam logic [4:0] ADDR_WAIT_PERIOD   = 5'h03;
	localparam logic [4:0] ADDR_LOW_THR_LO    = 5'h04;
	localparam logic [4:0] ADDR_LOW_THR_HI    = 5'h05;
	localparam logic [4:0] ADDR_HIGH_THR_LO   = 5'h06;
	localparam logic [4:0] ADDR_HIGH_THR_HI   = 5'h07;
	localparam logic [4:0] ADDR_INT_FILTER    = 5'h0c;
	localparam logic [4:0] ADDR_CONFIG        = 5'h0d;
	localparam logic [4:0] ADDR_STATUS        = 5'h13;
	localparam logic [4:0] ADDR_CLEAR_LO      = 5'h14;
	localparam logic [4:0] ADDR_CLEAR_HI      = 5'h15;

	// special function code that clears the pending interrupt
	localparam logic [4:0] SF_IRQ_CLEAR       = 5'h06;

	// field positions
	localparam int BIT_OSC_POWER_ON   = 0;
	localparam int BIT_CONV_ENABLE    = 1;
	localparam int BIT_WAIT_ENABLE    = 3;
	localparam int BIT_MEAS_IRQ_GATE  = 4;
	localparam int BIT_WAIT_STRETCH   = 1;
	localparam int BIT_RESULT_READY   = 0;
	localparam int BIT_CLEAR_IRQ_FLAG = 4;

	// writable bits of each control register
	localparam logic [7:0] FUNC_ENABLE_MASK = 8'h1b;
	localparam logic [7:0] CONFIG_MASK      = 8'h02;
	localparam logic [7:0] FILTER_MASK      = 8'h0f;

	// reset values
	localparam logic [7:0] RST_FUNC_ENABLE  = 8'h00;
	localparam logic [7:0] RST_PERIOD       = 8'hff;
	localparam logic [7:0] RST_ZERO         = 8'h00;

	// timing: one step is 2.4 ms at a 25 ns clock
	localparam int STEP_TIME_NS   = 2400000;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  STRETCH_LAST   = 4'hb;   // twelve sub-steps, 0..11
	localparam logic [8:0]  FULL_PERIOD    = 9'h100; // 256 steps
	localparam int          MAX_COUNT_SHIFT = 10;    // steps times 1024
	localparam logic [18:0] MAX_COUNT_SAT  = 19'h0ffff;

	// persistence coding
	localparam logic [3:0] FILTER_EVERY    = 4'h0;
	localparam logic [3:0] FILTER_LINEAR   = 4'h3;   // codes 1..3 need that many
	localparam logic [3:0] FILTER_STEP5    = 4'h7;   // from here (code-3)*5
	localparam logic [5:0] FILTER_FIVE     = 6'h05;
	localparam logic [5:0] FILTER_TEN      = 6'h0a;
	localparam logic [5:0] FILTER_FIFTEEN  = 6'h0f;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_WARM,
		ST_READY,
		ST_INTEG,
		ST_WAIT
	} csm_state_e;

	// one access on the internal register port
	typedef struct packed {
		logic       wr;     // write strobe
		logic       rd;     // read strobe
		logic [4:0] addr;   // register index
		logic [7:0] wdata;  // write data
	} csm_regbus_s;

	// special function command from the command decoder
	typedef struct packed {
		logic       valid;  // one-cycle strobe
		logic [4:0] code;   // special function field
	} csm_sfcmd_s;

	// whole state of the block
	typedef struct packed {
		logic [7:0]  func_enable;
		logic [7:0]  integration_period;
		logic [7:0]  wait_period;
		logic [15:0] low_threshold;
		logic [15:0] high_threshold;
		logic [7:0]  interrupt_filter;
		logic [7:0]  config_reg;
		csm_state_e  state;
		logic [16:0] cycle_cnt;
		logic [8:0]  step_cnt;
		logic [3:0]  stretch_cnt;
		logic [5:0]  persist_cnt;
		logic        result_ready;
		logic        clear_chan_irq_flag;
		logic [15:0] clear_data;
		logic [7:0]  rd_data;
		logic        integ_done;
	} csm_core_s;

endpackage
